/* File: design/lpt_hyst_expand.sv */
// Expands an 8-bit compressed code into a 16-bit magnitude.
// Assumes one clock; result lags the code by one cycle.
`timescale 1ns/1ps
`default_nettype none

`include "lpt_map.svh"

module lpt_hyst_expand
    import lpt_pkg::*;
(
    input  wire logic          clk_i,   // System clock
    input  wire logic          rst_i,   // Sync reset, high
    input  wire lpt_code8_type code_i,  // Compressed code
    output lpt_code16_type     mag_o    // Expanded value
);

    // ------------------------------------------------------
    // Expansion
    // ------------------------------------------------------
    logic [3:0]  exp_w;    // Power-of-two exponent
    logic [3:0]  man_w;    // Fraction in sixteenths
    logic [19:0] wide_w;   // (16 + man) << exp

    assign exp_w  = code_i[`LPT_EXP_MSB:`LPT_EXP_LSB];
    assign man_w  = code_i[`LPT_MAN_MSB:`LPT_MAN_LSB];
    // Top code 0xFF gives 31 << 15, still within 20 bits
    assign wide_w = {15'h0000, 1'b1, man_w} << exp_w;

    // Registered so the compare path stays short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mag_o <= 16'h0000;
        end else begin
            mag_o <= wide_w[19:4];   // [RULE_04] [RULE_05] [RULE_10]
        end
    end

endmodule

`default_nettype wire

/* File: design/lpt_map.svh */
// Register indices, field positions, reset values and counts
// for the light/proximity threshold and persistence block.
// Assumes a 32-bit Wishbone slave; byte address = 4 * index.
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// ----------------------------------------------------------
// Register indices (word index on the bus)
// ----------------------------------------------------------
`define LPT_IDX_VIS_CFG     8'h12
`define LPT_IDX_LIGHT_HYST  8'h16
`define LPT_IDX_PROX_HYST   8'h17
`define LPT_IDX_PROX_PERS   8'h18
`define LPT_IDX_LIGHT_PERS  8'h19
`define LPT_IDX_LIGHT_LO_TH 8'h20
`define LPT_IDX_LIGHT_HI_TH 8'h21
`define LPT_IDX_PROX1_TH    8'h22
`define LPT_IDX_PROX2_TH    8'h23
`define LPT_IDX_PROX3_TH    8'h24
`define LPT_IDX_STATUS      8'h28
`define LPT_IDX_IRQ_STAT    8'h29
`define LPT_IDX_IRQ_MASK    8'h2A

// ----------------------------------------------------------
// Fields
// ----------------------------------------------------------
`define LPT_VISIBLE_HIGH_RANGE_SELECT_BIT   5
`define LPT_EXP_MSB         7
`define LPT_EXP_LSB         4
`define LPT_MAN_MSB         3
`define LPT_MAN_LSB         0
`define LPT_NUM_CMP         5
`define LPT_IRQ_OVR_BIT     5
`define LPT_IRQ_W           6

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define LPT_RST_VIS_CFG     8'h00
`define LPT_RST_HYST        8'h48
`define LPT_RST_PERS        8'h03
`define LPT_RST_TH_LO       16'h0000
`define LPT_RST_TH_HI       16'hFFFF
`define LPT_RST_MASK        6'h00

// ----------------------------------------------------------
// Special codes
// ----------------------------------------------------------
`define LPT_OVERRANGE       16'hFFFF

`endif

/* File: design/lpt_pkg.sv */
// Types shared by the threshold/persistence block.
// Assumes lpt_map.svh supplies all numeric constants.
package lpt_pkg;

    // ------------------------------------------------------
    // Types
    // ------------------------------------------------------
    typedef logic [15:0] lpt_code16_type;   // Expanded magnitude
    typedef logic [7:0]  lpt_code8_type;    // Compressed code

    // Comparator slots, in status-bit order
    typedef enum logic [4:0] {
        LPT_CMP_LIGHT_LO = 5'b00001,
        LPT_CMP_LIGHT_HI = 5'b00010,
        LPT_CMP_PROX1    = 5'b00100,
        LPT_CMP_PROX2    = 5'b01000,
        LPT_CMP_PROX3    = 5'b10000
    } lpt_cmp_type;

endpackage

/* File: design/lpt_threshold_top.sv */
// Threshold, hysteresis and persistence decisions for a
// light/proximity sensor, with Wishbone registers and an
// interrupt. Assumes samples arrive as one-cycle valid
// strobes synchronous to clk_i.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

`include "lpt_map.svh"

// Behaviour
// RULE_01 - Config bit 5 selects high visible range
// RULE_02 - Light hysteresis widens both light thresholds
// RULE_03 - One proximity hysteresis for three channels
// RULE_04 - Hysteresis stored compressed, expanded to 16 bits
// RULE_05 - Code 0x48 expands to 24 codes
// RULE_06 - Status changes only after full consecutive run
// RULE_07 - Proximity persistence code sets sample count
// RULE_08 - Light persistence uses same encoding separately
// RULE_09 - Proximity hysteresis resets to 0x48
// RULE_10 - Upper nibble is power-of-two exponent
// RULE_11 - All-ones sample is overrange, not compared
// RULE_12 - Persistence mask selects required history bits
// RULE_13 - Reserved config bits read zero
module lpt_threshold_top
    import lpt_pkg::*;
#(
    parameter int ADR_W = 10           // Byte address width
)(
    input  wire logic             clk_i,            // Clock
    input  wire logic             rst_i,            // Sync reset
    input  wire logic             wb_cyc_i,         // Bus cycle
    input  wire logic             wb_stb_i,         // Strobe
    input  wire logic             wb_we_i,          // Write
    input  wire logic [ADR_W-1:0] wb_adr_i,         // Byte addr
    input  wire logic [3:0]       wb_sel_i,         // Lanes
    input  wire logic [31:0]      wb_dat_i,         // Write data
    output logic      [31:0]      wb_dat_o,         // Read data
    output logic                  wb_ack_o,         // Ack
    input  wire logic             light_valid_i,    // Light strobe
    input  wire logic [15:0]      light_sample_i,   // Light value
    input  wire logic             prox_valid_i,     // Prox strobe
    input  wire logic [15:0]      prox1_sample_i,   // Channel 1
    input  wire logic [15:0]      prox2_sample_i,   // Channel 2
    input  wire logic [15:0]      prox3_sample_i,   // Channel 3
    output logic                  visible_high_range_select_o, // Range
    output logic      [4:0]       threshold_status_o, // Decisions
    output logic                  irq_o             // Interrupt
);

    // ------------------------------------------------------
    // Registers
    // ------------------------------------------------------
    logic                 visible_high_range_select_r;   // Visible range bit
    lpt_code8_type        light_hyst_r;  // Light hysteresis
    lpt_code8_type        prox_hyst_r;   // Prox hysteresis
    lpt_code8_type        prox_pers_r;   // Prox persistence
    lpt_code8_type        light_pers_r;  // Light persistence
    lpt_code16_type       th_r [`LPT_NUM_CMP]; // Thresholds
    logic [`LPT_IRQ_W-1:0] irq_stat_r;   // Sticky events
    logic [`LPT_IRQ_W-1:0] irq_mask_r;   // Event enables
    logic                 ack_r;         // Bus answer
    logic [31:0]          rdat_r;        // Read data

    // ------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------
    logic       req_w;     // New request this cycle
    logic       wr_w;      // Write takes effect
    logic [7:0] idx_w;     // Word index
    logic       lane0_w;   // Low byte written
    logic       lane1_w;   // Second byte written

    // Ack high for one cycle; a held request is taken once
    assign req_w   = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_w    = req_w && wb_we_i;
    assign idx_w   = 8'(wb_adr_i[ADR_W-1:2]);
    assign lane0_w = wr_w && wb_sel_i[0];
    assign lane1_w = wr_w && wb_sel_i[1];

    // ------------------------------------------------------
    // Ack generation
    // ------------------------------------------------------
    // One wait cycle; unmapped addresses are answered too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_w;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------
    // Visible range configuration
    // ------------------------------------------------------
    // Only bit 5 is stored; other bits are not kept at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            visible_high_range_select_r <= 1'(`LPT_RST_VIS_CFG >> `LPT_VISIBLE_HIGH_RANGE_SELECT_BIT);
        end else if (lane0_w && idx_w == `LPT_IDX_VIS_CFG) begin
            visible_high_range_select_r <= wb_dat_i[`LPT_VISIBLE_HIGH_RANGE_SELECT_BIT]; // [RULE_01]
        end
    end

    // Drives the ADC gain path: 1 means gain divided by 14.5
    assign visible_high_range_select_o = visible_high_range_select_r; // [RULE_01]

    // ------------------------------------------------------
    // Hysteresis and persistence codes
    // ------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            light_hyst_r <= `LPT_RST_HYST;
            prox_hyst_r  <= `LPT_RST_HYST;    // [RULE_09]
            prox_pers_r  <= `LPT_RST_PERS;
            light_pers_r <= `LPT_RST_PERS;
        end else if (lane0_w) begin
            case (idx_w)
                `LPT_IDX_LIGHT_HYST: begin
                    light_hyst_r <= wb_dat_i[7:0];
                end
                `LPT_IDX_PROX_HYST: begin
                    prox_hyst_r <= wb_dat_i[7:0];
                end
                `LPT_IDX_PROX_PERS: begin
                    prox_pers_r <= wb_dat_i[7:0];  // [RULE_07]
                end
                `LPT_IDX_LIGHT_PERS: begin
                    light_pers_r <= wb_dat_i[7:0]; // [RULE_08]
                end
                default: begin
                    // Other indices leave these alone
                end
            endcase
        end
    end

    // ------------------------------------------------------
    // Threshold registers, one per comparator
    // ------------------------------------------------------
    genvar gt;
    generate
        for (gt = 0; gt < `LPT_NUM_CMP; gt++) begin : g_th
            // Light lower threshold starts low, others high
            localparam lpt_code16_type TH_RST =
                (gt == 0) ? `LPT_RST_TH_LO : `LPT_RST_TH_HI;
            localparam logic [7:0] TH_IDX =
                8'(`LPT_IDX_LIGHT_LO_TH + gt);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    th_r[gt] <= TH_RST;
                end else if (idx_w == TH_IDX) begin
                    if (lane0_w) begin
                        th_r[gt][7:0] <= wb_dat_i[7:0];
                    end
                    if (lane1_w) begin
                        th_r[gt][15:8] <= wb_dat_i[15:8];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------
    // Hysteresis expansion
    // ------------------------------------------------------
    lpt_code16_type light_hmag_w;  // Light margin, 16 bits
    lpt_code16_type prox_hmag_w;   // Prox margin, 16 bits

    lpt_hyst_expand u_light_exp (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .code_i (light_hyst_r),
        .mag_o  (light_hmag_w)
    );

    lpt_hyst_expand u_prox_exp (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .code_i (prox_hyst_r),
        .mag_o  (prox_hmag_w)
    );

    // ------------------------------------------------------
    // Per-comparator inputs
    // ------------------------------------------------------
    lpt_code16_type samp_w [`LPT_NUM_CMP]; // Sample per slot
    lpt_code16_type hmag_w [`LPT_NUM_CMP]; // Margin per slot
    lpt_code8_type  mask_w [`LPT_NUM_CMP]; // Persistence mask
    logic [`LPT_NUM_CMP-1:0] vld_w;        // Sample strobes

    // Light slots share light settings, prox slots share prox
    always_comb begin
        samp_w[0] = light_sample_i;
        samp_w[1] = light_sample_i;
        samp_w[2] = prox1_sample_i;
        samp_w[3] = prox2_sample_i;
        samp_w[4] = prox3_sample_i;
        hmag_w[0] = light_hmag_w;          // [RULE_02]
        hmag_w[1] = light_hmag_w;          // [RULE_02]
        hmag_w[2] = prox_hmag_w;           // [RULE_03]
        hmag_w[3] = prox_hmag_w;           // [RULE_03]
        hmag_w[4] = prox_hmag_w;           // [RULE_03]
        mask_w[0] = light_pers_r;          // [RULE_08]
        mask_w[1] = light_pers_r;          // [RULE_08]
        mask_w[2] = prox_pers_r;           // [RULE_07]
        mask_w[3] = prox_pers_r;           // [RULE_07]
        mask_w[4] = prox_pers_r;           // [RULE_07]
        vld_w     = {{3{prox_valid_i}}, {2{light_valid_i}}};
    end

    // ------------------------------------------------------
    // Comparators with persistence history
    // ------------------------------------------------------
    logic [`LPT_NUM_CMP-1:0] st_w;   // Decision per slot
    logic [`LPT_NUM_CMP-1:0] chg_w;  // Decision flipped
    logic [`LPT_NUM_CMP-1:0] ovr_w;  // Overrange seen

    genvar gc;
    generate
        for (gc = 0; gc < `LPT_NUM_CMP; gc++) begin : g_cmp
            localparam bit BELOW = (gc == 0); // Lower threshold
            logic [17:0] s18_w;    // Sample, widened
            logic [17:0] hi18_w;   // Threshold plus margin
            logic [17:0] lo18_w;   // Threshold minus margin
            logic        above_w;  // Past the upper edge
            logic        below_w;  // Past the lower edge
            logic        cross_w;  // Toward the other state
            logic        done_w;   // Run long enough
            logic [7:0]  hist_r;   // Past crossing results
            logic [7:0]  hist_nxt; // History with this sample
            logic        st_r;     // Current decision

            assign s18_w  = {2'b00, samp_w[gc]};
            assign hi18_w = {2'b00, th_r[gc]} + {2'b00, hmag_w[gc]};
            // Signed so a margin larger than the threshold
            // cannot wrap and fire on every sample
            assign lo18_w = {2'b00, th_r[gc]} - {2'b00, hmag_w[gc]};
            assign above_w = $signed(s18_w) > $signed(hi18_w);
            assign below_w = $signed(s18_w) < $signed(lo18_w);

            // Leaving a state needs the margin the other way
            assign cross_w = st_r ? (BELOW ? above_w : below_w)
                                  : (BELOW ? below_w : above_w);

            // Overrange code is no measurement
            assign ovr_w[gc] = vld_w[gc] &&
                               samp_w[gc] == `LPT_OVERRANGE; // [RULE_11]

            assign hist_nxt = {hist_r[6:0], cross_w};
            // Every masked history bit must show a crossing
            assign done_w = cross_w &&
                ((hist_nxt & mask_w[gc]) == mask_w[gc]); // [RULE_06] [RULE_12]

            assign chg_w[gc] = vld_w[gc] && !ovr_w[gc] && done_w;
            assign st_w[gc]  = st_r;

            // History and decision advance only on valid samples
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    hist_r <= 8'h00;
                    st_r   <= 1'b0;
                end else if (vld_w[gc] && !ovr_w[gc]) begin // [RULE_11]
                    if (done_w) begin
                        st_r   <= !st_r;           // [RULE_06]
                        hist_r <= 8'h00;           // Fresh run
                    end else begin
                        hist_r <= hist_nxt;        // [RULE_12]
                    end
                end
            end
        end
    endgenerate

    assign threshold_status_o = st_w;

    // ------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------
    logic [`LPT_IRQ_W-1:0] evt_w;  // Events this cycle
    logic [`LPT_IRQ_W-1:0] clr_w;  // Write-one-to-clear

    assign evt_w = {|ovr_w, chg_w};
    assign clr_w = (lane0_w && idx_w == `LPT_IDX_IRQ_STAT) ?
                   wb_dat_i[`LPT_IRQ_W-1:0] : '0;

    // Set beats clear, so no event is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr_w) | evt_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= `LPT_RST_MASK;
        end else if (lane0_w && idx_w == `LPT_IDX_IRQ_MASK) begin
            irq_mask_r <= wb_dat_i[`LPT_IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------
    // Read data
    // ------------------------------------------------------
    // Registered with the ack; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0000_0000;
        end else if (req_w && !wb_we_i) begin
            rdat_r <= 32'h0000_0000;
            case (idx_w)
                `LPT_IDX_VIS_CFG: begin
                    // Reserved bits stay zero
                    rdat_r[`LPT_VISIBLE_HIGH_RANGE_SELECT_BIT] <= visible_high_range_select_r; // [RULE_13]
                end
                `LPT_IDX_LIGHT_HYST: begin
                    rdat_r[7:0] <= light_hyst_r;
                end
                `LPT_IDX_PROX_HYST: begin
                    rdat_r[7:0] <= prox_hyst_r;
                end
                `LPT_IDX_PROX_PERS: begin
                    rdat_r[7:0] <= prox_pers_r;
                end
                `LPT_IDX_LIGHT_PERS: begin
                    rdat_r[7:0] <= light_pers_r;
                end
                `LPT_IDX_LIGHT_LO_TH: begin
                    rdat_r[15:0] <= th_r[0];
                end
                `LPT_IDX_LIGHT_HI_TH: begin
                    rdat_r[15:0] <= th_r[1];
                end
                `LPT_IDX_PROX1_TH: begin
                    rdat_r[15:0] <= th_r[2];
                end
                `LPT_IDX_PROX2_TH: begin
                    rdat_r[15:0] <= th_r[3];
                end
                `LPT_IDX_PROX3_TH: begin
                    rdat_r[15:0] <= th_r[4];
                end
                `LPT_IDX_STATUS: begin
                    rdat_r[`LPT_NUM_CMP-1:0] <= st_w;
                end
                `LPT_IDX_IRQ_STAT: begin
                    rdat_r[`LPT_IRQ_W-1:0] <= irq_stat_r;
                end
                `LPT_IDX_IRQ_MASK: begin
                    rdat_r[`LPT_IRQ_W-1:0] <= irq_mask_r;
                end
                default: begin
                    // Unmapped: zero
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: tb/lpt_host_model.sv */
// Host processor stand-in: a classic Wishbone master.
// Assumes one clock; callers issue one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
module lpt_host_model (
    input  wire logic        clk_i, // Clock
    output logic             cyc_o, // Bus cycle
    output logic             stb_o, // Strobe
    output logic             we_o,  // Write
    output logic [9:0]       adr_o, // Byte address
    output logic [3:0]       sel_o, // Lanes
    output logic [31:0]      dat_o, // Write data
    input  wire logic        ack_i, // Ack
    input  wire logic [31:0] dat_i  // Read data
);
    // Idle bus at time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // One transfer; held until ack, released on that edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'b11, w};
        adr_o <= {idx, 2'b00};
        sel_o <= 4'hF;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'h0;
        dat_o <= ~d; // Stale data is not left standing
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 32'h0, q);
    endtask
endmodule
`default_nettype wire

/* File: tb/lpt_threshold_asserts.sv */
// Port-level checks for the threshold block.
// Assumes single-cycle Wishbone requests and strobed samples.
`timescale 1ns/1ps
`default_nettype none
module lpt_threshold_asserts (
    input wire logic        clk_i, // Clock
    input wire logic        rst_i, // Sync reset
    input wire logic        wb_cyc_i, // Bus cycle
    input wire logic        wb_stb_i, // Strobe
    input wire logic        wb_we_i, // Write
    input wire logic        wb_ack_o, // Ack
    input wire logic        light_valid_i, // Light strobe
    input wire logic [15:0] light_sample_i, // Light value
    input wire logic        prox_valid_i, // Prox strobe
    input wire logic        visible_high_range_select_o, // Range
    input wire logic [4:0]  threshold_status_o, // Decisions
    input wire logic        irq_o // Interrupt
);
    // --------
    // Clocking and sequences
    // --------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // New request not yet answered
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Overrange light sample offered
    sequence light_ovr_s;
        light_valid_i && light_sample_i == 16'hFFFF;
    endsequence
    // --------
    // Assertions
    // --------
    ack_latency_a: assert property (req_s |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    irq_cause_a: assert property ($rose(irq_o) |-> $past(light_valid_i || prox_valid_i || (wb_cyc_i && wb_we_i)))
        else $error("irq rose without sample or write");
    range_write_a: assert property ($changed(visible_high_range_select_o) |-> $past(wb_cyc_i && wb_we_i))
        else $error("range output moved without write");
    status_run_a: assert property ($changed(threshold_status_o) |-> $past(light_valid_i || prox_valid_i))
        else $error("status moved without a sample");
    prox_own_a: assert property ($changed(threshold_status_o[4:2]) |-> $past(prox_valid_i))
        else $error("prox status moved without sample");
    light_own_a: assert property ($changed(threshold_status_o[1:0]) |-> $past(light_valid_i))
        else $error("light status moved without sample");
    overrange_hold_a: assert property (light_ovr_s |=> $stable(threshold_status_o[1:0]))
        else $error("overrange sample changed light status");
endmodule
bind lpt_threshold_top lpt_threshold_asserts lpt_threshold_asserts_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .light_valid_i, .light_sample_i, .prox_valid_i, .visible_high_range_select_o,
    .threshold_status_o, .irq_o);
`default_nettype wire

/* File: tb/tb_light_prox_threshold_persistence.sv */
// Self-checking bench for the threshold/persistence block.
// Assumes lpt_host_model drives the bus; samples come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_light_prox_threshold_persistence;
    logic        clk_i = 1'b0, rst_i = 1'b1, lv = 1'b0, pv = 1'b0; // Clock, reset, strobes
    logic        cyc, stb, we, ack, vis, irq; // Bus and outputs
    logic [9:0]  adr; // Byte address
    logic [3:0]  sel; // Lanes
    logic [31:0] wdat, rdat, q; // Bus data
    logic [15:0] ls = '0, p1 = '0, p2 = '0, p3 = '0; // Samples
    logic [4:0]  st; // Decisions
    int          num_errors = 0, n_compared = 0; // Counters
    logic [7:0]  ridx [9] = '{8'h12, 8'h16, 8'h17, 8'h18, 8'h19, 8'h3F, 8'h28, 8'h29, 8'h2A};
    logic [31:0] rexp [9] = '{32'h0, 32'h48, 32'h48, 32'h3, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [7:0]  masks [4] = '{8'h00, 8'h03, 8'h07, 8'hFF}; // Persistence codes
    logic [7:0]  codes [4] = '{8'h48, 8'h60, 8'h70, 8'h80}; // Hysteresis codes
    always #5 clk_i = ~clk_i;
    lpt_host_model lpt_host_model_inst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
    lpt_threshold_top lpt_threshold_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .light_valid_i(lv), .light_sample_i(ls), .prox_valid_i(pv), .prox1_sample_i(p1), .prox2_sample_i(p2),
        .prox3_sample_i(p3), .visible_high_range_select_o(vis), .threshold_status_o(st), .irq_o(irq));
    // --------
    // Helpers
    // --------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Margin: hidden-16 mantissa shifted by exponent
    function logic [15:0] exp_h(input logic [7:0] c);
        return 16'(((32'd16 + 32'(c[3:0])) << c[7:4]) >> 4);
    endfunction
    // Samples a low-ones mask needs; empty mask needs one
    function int runlen(input logic [7:0] m);
        int n;
        n = 1;
        for (int b = 0; b < 8; b++) if (m[b]) n = b + 1;
        return n;
    endfunction
    // k one-cycle strobes, then an idle edge
    task give(input int ch, input logic [15:0] v, input int k);
        repeat (k) begin
            @(posedge clk_i);
            {lv, pv, ls} <= {ch < 2, ch >= 2, v};
            p1 <= (ch == 2) ? v : 16'h0;
            p2 <= (ch == 3) ? v : 16'h0;
            p3 <= (ch == 4) ? v : 16'h0;
            @(posedge clk_i);
            {lv, pv, ls} <= {2'b00, ~v};
        end
        @(posedge clk_i);
    endtask
    // One channel: boundary, broken run, overrange (light channels only), flip, release, irq
    task run(input int ch, input logic [7:0] m, input logic [7:0] c, input logic [15:0] t);
        logic [15:0] h, hit, bnd, rel;
        int n;
        h = exp_h(c);
        n = runlen(m);
        bnd = (ch == 0) ? t - h : t + h;
        hit = (ch == 0) ? t - h - 16'h1 : t + h + 16'h1;
        rel = (ch == 0) ? t + h + 16'h1 : t - h - 16'h1;
        lpt_host_model_inst.wr(8'(8'h20 + ch), 32'(t));
        lpt_host_model_inst.wr(ch < 2 ? 8'h16 : 8'h17, 32'(c));
        lpt_host_model_inst.wr(ch < 2 ? 8'h19 : 8'h18, 32'(m));
        @(posedge clk_i); // Expander register settles
        give(ch, bnd, n + 1);
        check(32'(st), 32'h0);
        give(ch, hit, n - 1);
        give(ch, bnd, 1);
        give(ch, hit, n - 1);
        if (ch < 2) give(ch, 16'hFFFF, 1);
        check(32'(st), 32'h0);
        give(ch, hit, 1);
        check(32'(st), 32'(1 << ch));
        give(ch, rel, n);
        check(32'(st), 32'h0);
        lpt_host_model_inst.rd(8'h29, q);
        check(q, 32'(1 << ch) | (ch < 2 ? 32'h20 : 32'h0));
        lpt_host_model_inst.wr(8'h2A, 32'(1 << ch));
        check(32'(irq), 32'h1);
        lpt_host_model_inst.wr(8'h29, 32'h3F);
        check(32'(irq), 32'h0);
        lpt_host_model_inst.wr(8'h2A, 32'h0);
        lpt_host_model_inst.wr(8'(8'h20 + ch), ch == 0 ? 32'h0 : 32'hFFFF);
        $display("test channel %0d mask %h code %h done", ch, m, c);
    endtask
    // --------
    // Main sequence and watchdog
    // --------
    initial begin
        void'($urandom(32'h1913d4ce));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ridx[i]) begin
            lpt_host_model_inst.rd(ridx[i], q);
            check(q, rexp[i]);
        end
        $display("test reset values done");
        lpt_host_model_inst.wr(8'h12, 32'h20); // Reserved bits zero
        @(posedge clk_i);
        check(32'(vis), 32'h1);
        lpt_host_model_inst.wr(8'h12, 32'hFF); // Deliberate reserved ones
        lpt_host_model_inst.rd(8'h12, q);
        check(q, 32'h20);
        lpt_host_model_inst.wr(8'h12, 32'h0);
        @(posedge clk_i);
        check(32'(vis), 32'h0);
        $display("test range select done");
        for (int i = 0; i < 10; i++)
            run(i % 5, masks[i % 4], i < 4 ? codes[i] : {4'($urandom % 9), 4'($urandom)},
                16'($urandom_range(40000, 4096)));
        stop_test();
    end
    // A few thousand cycles suffice; cuts a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
